/* File: logic/amsc_pkg.sv */
/*
  shared constants, types and helper functions for the accelerometer
  mode and sampling control block.
  assumes a single 10 mhz system clock and a 32-bit ahb-lite register bus.
*/
package amsc_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS       = 100;        // hclk period
  localparam int FAST_RATE_PERIOD_NS = 2_500_000;  // period of the 400 hz rate
  localparam int FAST_RATE_CYCLES    = FAST_RATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int EXT_EDGES_PER_FAST  = 128;        // external clock edges per 400 hz period
  localparam int DIV_W               = 20;         // width of the base divider
  localparam int OCT_W               = 6;          // octave counter for slower rates

  // ==========================================================================
  // rate codes: 0 = 12.5 hz ... 5 = 400 hz, each step doubles
  localparam logic [2:0] RATE_CODE_MAX = 3'h5;
  localparam logic [2:0] WAKE_SHIFT    = 3'h6;     // 400 hz / 64 = 6.25 hz

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_DATA_X   = 8'h08;
  localparam logic [7:0] OFS_DATA_Y   = 8'h0C;
  localparam logic [7:0] OFS_DATA_Z   = 8'h10;
  localparam logic [7:0] OFS_THRESH   = 8'h14;
  localparam logic [7:0] OFS_ACT_TIME = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // ==========================================================================
  // control register layout
  localparam int CTRL_MODE_LSB  = 0;   // two bits
  localparam int CTRL_RATE_LSB  = 2;   // three bits
  localparam int CTRL_FILTER_BANDWIDTH_SELECT   = 5;   // filter_bandwidth_select: 1 = half, 0 = quarter
  localparam int CTRL_RANGE_LSB = 6;   // two bits
  localparam int CTRL_EXT_CLK   = 8;
  localparam int CTRL_EXT_TRIG  = 9;
  localparam int CTRL_AUTO_MEAS = 10;
  localparam int CTRL_WAKE_OUT  = 11;
  localparam int CTRL_FIFO_EN   = 12;
  localparam int CTRL_W         = 13;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h000C;  // standby, 100 hz, quarter bw

  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKEUP  = 2'h1;
  localparam logic [1:0] MODE_MEASURE = 2'h2;

  // ==========================================================================
  // status and interrupt layout
  localparam int ST_DATA_VALID = 2;    // bits 1:0 hold the mode code
  localparam int ST_AWAKE      = 3;
  localparam int IRQ_DATA      = 0;
  localparam int IRQ_MOTION    = 1;
  localparam int IRQ_W         = 2;

  // ==========================================================================
  // data widths and reset values
  localparam int SAMPLE_W = 12;
  localparam int THRESH_W = 11;
  localparam int ACT_W    = 8;
  localparam logic [THRESH_W-1:0] THRESH_RESET = 11'h0FA;
  localparam logic [ACT_W-1:0]    ACT_RESET    = 8'h01;

  typedef enum logic [1:0] {AMSC_STANDBY, AMSC_WAKEUP, AMSC_MEASURE} amsc_mode_e;

  // magnitude of a two's complement sample
  function automatic logic [SAMPLE_W-1:0] amsc_abs(input logic [SAMPLE_W-1:0] v);
    amsc_abs = v[SAMPLE_W-1] ? SAMPLE_W'(~v + 12'h001) : v;
  endfunction

  // true when the octave count lands on a multiple of 2**shift
  function automatic logic amsc_rate_hit(input logic [OCT_W-1:0] oct,
                                         input logic [2:0]       shift);
    logic [OCT_W:0] mask;
    mask          = 7'((7'h01 << shift) - 7'h01);
    amsc_rate_hit = ((oct & mask[OCT_W-1:0]) == 6'h00);
  endfunction

endpackage

/* File: logic/amsc_sync_edge.sv */
/*
  two flop synchroniser with rising edge detect for a pin input.
  assumes the pin is asynchronous to hclk; the first flop feeds only the second.
*/
`timescale 1ns/1ns
module amsc_sync_edge
  import amsc_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic meta_q, meta_d;   // first stage, read only by the second
  logic sync_q, sync_d;   // stable copy
  logic prev_q, prev_d;   // delayed copy for the edge

  // ==========================================================================
  // next values
  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;   // one cycle per rising edge

endmodule

/* File: logic/amsc_divider.sv */
/*
  event divider: emits one pulse for every div step events.
  assumes div is at least one and steady while counting; clear restarts it.
*/
`timescale 1ns/1ns
module amsc_divider
  import amsc_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clear,
  input  wire logic             step,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt_q, cnt_d;   // events seen in this period
  logic             tick_q, tick_d;

  // ==========================================================================
  // next values
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (clear) begin
      // restart so the first period after a mode change is whole
      cnt_d = '0;
    end else if (step) begin
      if (cnt_q >= DIV_W'(div - 20'h0_0001)) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = DIV_W'(cnt_q + 20'h0_0001);
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

/* File: logic/amsc_top.sv */
/*
  mode and sampling control of a three axis accelerometer: standby, wake-up
  and measurement modes, rate and filter selection, 12-bit sample capture,
  motion detection, interrupts, and the two dual use interrupt pins.
  assumes an ahb-lite master with single word transfers, a converter front end
  whose axis values are steady on hclk, and a fifo outside that takes pushes.
*/
`timescale 1ns/1ns
// Operation
// - reset leaves standby, sensing off
// - standby halts sampling, keeps interrupt flags and data
// - wake-up samples about six per second
// - wake-up motion: measure, interrupt, wake output
// - wake-up skips activity timer, rest works
// - wake-up keeps registers, data, fifo pushes
// - rates from 12.5 hz to 400 hz
// - one conversion per selected output period
// - filter corner half or quarter rate
// - filter defaults to quarter rate
// - always 12-bit samples, range scales weight
// - second pin may be trigger input
// - first pin may be external clock input
// - valid data within four periods
module amsc_top
  import amsc_pkg::*;
#(
  parameter int FAST_RATE_DIV = FAST_RATE_CYCLES,   // hclk cycles per 400 hz period
  parameter int EXT_DIV       = EXT_EDGES_PER_FAST  // external edges per 400 hz period
)(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [SAMPLE_W-1:0] accel_x,
  input  wire logic [SAMPLE_W-1:0] accel_y,
  input  wire logic [SAMPLE_W-1:0] accel_z,
  output logic                     sense_enable,
  output logic                     convert_strobe,
  output logic                     filter_bandwidth_select,
  output logic [1:0]               range_select,
  output logic                     fifo_push,
  output logic [3*SAMPLE_W-1:0]    fifo_data,
  output logic                     irq,
  input  wire logic                first_interrupt_pin_level,
  output logic                     first_interrupt_pin_drive,
  output logic                     first_interrupt_pin_oe,
  input  wire logic                second_interrupt_pin_level,
  output logic                     second_interrupt_pin_drive,
  output logic                     second_interrupt_pin_oe
);

  // ==========================================================================
  // state
  logic [CTRL_W-1:0]     ctrl_q, ctrl_d;         // control register
  amsc_mode_e            mode_q, mode_d;         // operating mode
  logic [THRESH_W-1:0]   thresh_q, thresh_d;     // motion threshold
  logic [ACT_W-1:0]      act_time_q, act_time_d; // activity samples needed
  logic [ACT_W-1:0]      act_cnt_q, act_cnt_d;   // consecutive samples above
  logic [SAMPLE_W-1:0]   data_x_q, data_x_d;     // latest samples
  logic [SAMPLE_W-1:0]   data_y_q, data_y_d;
  logic [SAMPLE_W-1:0]   data_z_q, data_z_d;
  logic                  valid_q, valid_d;       // a sample was taken
  logic                  awake_q, awake_d;       // motion seen
  logic [IRQ_W-1:0]      istat_q, istat_d;       // sticky interrupt flags
  logic [IRQ_W-1:0]      imask_q, imask_d;       // interrupt enables
  logic [OCT_W-1:0]      oct_q, oct_d;           // base ticks since mode entry
  logic                  conv_q, conv_d;         // conversion strobe
  logic                  push_q, push_d;         // fifo push strobe
  logic [3*SAMPLE_W-1:0] fdata_q, fdata_d;       // fifo word
  logic                  pend_q, pend_d;         // data phase in progress
  logic                  pwr_q, pwr_d;           // pending access is a write
  logic [7:0]            paddr_q, paddr_d;       // pending word address
  logic [31:0]           rdata_q, rdata_d;       // read data register

  // ==========================================================================
  // derived controls
  logic       ext_clk_en;
  logic       ext_trig_en;
  logic [2:0] rate_code;
  logic [2:0] rate_shift;
  logic       mode_clear;
  logic       base_tick;
  logic       ext_clk_rise;
  logic       trig_rise;
  logic       sample_now;
  logic       over;
  logic       motion;
  logic       ctrl_wr;
  logic       addr_ok;

  assign ext_clk_en  = ctrl_q[CTRL_EXT_CLK];
  assign ext_trig_en = ctrl_q[CTRL_EXT_TRIG];
  assign rate_code   = ctrl_q[CTRL_RATE_LSB +: 3];
  // codes past 400 hz clamp to the fastest rate
  assign rate_shift  = (rate_code > RATE_CODE_MAX) ? 3'h0 : 3'(RATE_CODE_MAX - rate_code);

  // ==========================================================================
  // pin inputs: both pass two flops before use
  amsc_sync_edge u_clk_pin (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (first_interrupt_pin_level),
    .level   (),
    .rise    (ext_clk_rise)
  );

  amsc_sync_edge u_trig_pin (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (second_interrupt_pin_level),
    .level   (),
    .rise    (trig_rise)
  );

  // ==========================================================================
  // base timebase: internal hclk count or external clock edges
  assign mode_clear = (mode_q != mode_d) | (mode_q == AMSC_STANDBY);

  amsc_divider u_base (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (mode_clear),
    .step    (ext_clk_en ? ext_clk_rise : 1'b1),
    .div     (ext_clk_en ? DIV_W'(EXT_DIV) : DIV_W'(FAST_RATE_DIV)),
    .tick    (base_tick)
  );

  // ==========================================================================
  // sample scheduling per mode
  always_comb begin
    unique case (mode_q)
      AMSC_STANDBY: sample_now = 1'b0;
      AMSC_WAKEUP:  sample_now = base_tick & amsc_rate_hit(oct_q, WAKE_SHIFT);
      // an external trigger replaces the rate timer in measurement
      AMSC_MEASURE: sample_now = ext_trig_en ? trig_rise
                               : base_tick & amsc_rate_hit(oct_q, rate_shift);
    endcase
  end

  // any axis magnitude above the threshold counts as motion
  assign over = (amsc_abs(accel_x) > {1'b0, thresh_q}) |
                (amsc_abs(accel_y) > {1'b0, thresh_q}) |
                (amsc_abs(accel_z) > {1'b0, thresh_q});

  // ==========================================================================
  // sampling and motion next values
  always_comb begin
    oct_d     = oct_q;
    act_cnt_d = act_cnt_q;
    data_x_d  = data_x_q;
    data_y_d  = data_y_q;
    data_z_d  = data_z_q;
    valid_d   = valid_q;
    conv_d    = sample_now;
    push_d    = 1'b0;
    fdata_d   = fdata_q;
    motion    = 1'b0;
    if (mode_clear) begin
      oct_d = '0;  // first sample lands one base period after entry
    end else if (base_tick) begin
      oct_d = OCT_W'(oct_q + 6'h01);
    end
    if (sample_now) begin
      // the full 12-bit word is kept whatever the range
      data_x_d = accel_x;
      data_y_d = accel_y;
      data_z_d = accel_z;
      valid_d  = 1'b1;
      push_d   = ctrl_q[CTRL_FIFO_EN];
      fdata_d  = {accel_z, accel_y, accel_x};
      if (!over) begin
        act_cnt_d = '0;
      end else if (mode_q == AMSC_WAKEUP) begin
        motion    = 1'b1;
        act_cnt_d = '0;
      end else if (ACT_W'(act_cnt_q + 8'h01) >= act_time_q) begin
        motion    = 1'b1;
        act_cnt_d = '0;
      end else begin
        act_cnt_d = ACT_W'(act_cnt_q + 8'h01);
      end
    end
  end

  // ==========================================================================
  // ahb-lite slave: one wait state, read data from a register
  assign addr_ok = (paddr_q == OFS_CTRL)     | (paddr_q == OFS_STATUS)   |
                   (paddr_q == OFS_DATA_X)   | (paddr_q == OFS_DATA_Y)   |
                   (paddr_q == OFS_DATA_Z)   | (paddr_q == OFS_THRESH)   |
                   (paddr_q == OFS_ACT_TIME) | (paddr_q == OFS_IRQ_STAT) |
                   (paddr_q == OFS_IRQ_MASK);
  assign ctrl_wr = pend_q & pwr_q & (paddr_q == OFS_CTRL);

  always_comb begin
    pend_d     = 1'b0;
    pwr_d      = pwr_q;
    paddr_d    = paddr_q;
    rdata_d    = rdata_q;
    ctrl_d     = ctrl_q;
    thresh_d   = thresh_q;
    act_time_d = act_time_q;
    imask_d    = imask_q;
    istat_d    = istat_q;
    mode_d     = mode_q;
    awake_d    = awake_q;
    // address phase taken only when the bus is ready
    if (hsel & htrans[1] & hready & !pend_q) begin
      pend_d  = 1'b1;
      pwr_d   = hwrite;
      paddr_d = {haddr[7:2], 2'b00};
    end
    if (pend_q & pwr_q) begin
      unique case (paddr_q)
        OFS_CTRL:     ctrl_d     = hwdata[CTRL_W-1:0];
        OFS_THRESH:   thresh_d   = hwdata[THRESH_W-1:0];
        OFS_ACT_TIME: act_time_d = hwdata[ACT_W-1:0];
        OFS_IRQ_MASK: imask_d    = hwdata[IRQ_W-1:0];
        OFS_IRQ_STAT: istat_d    = istat_q & ~hwdata[IRQ_W-1:0];
        default:      ctrl_d     = ctrl_q;  // unmapped write ignored
      endcase
    end
    if (pend_q & !pwr_q) begin
      rdata_d = '0;
      unique case (paddr_q)
        OFS_CTRL:     rdata_d[CTRL_W-1:0]   = ctrl_q;
        OFS_STATUS:   rdata_d[ST_AWAKE:0]   = {awake_q, valid_q, ctrl_q[1:0]};
        OFS_DATA_X:   rdata_d[SAMPLE_W-1:0] = data_x_q;
        OFS_DATA_Y:   rdata_d[SAMPLE_W-1:0] = data_y_q;
        OFS_DATA_Z:   rdata_d[SAMPLE_W-1:0] = data_z_q;
        OFS_THRESH:   rdata_d[THRESH_W-1:0] = thresh_q;
        OFS_ACT_TIME: rdata_d[ACT_W-1:0]    = act_time_q;
        OFS_IRQ_STAT: rdata_d[IRQ_W-1:0]    = istat_q;
        OFS_IRQ_MASK: rdata_d[IRQ_W-1:0]    = imask_q;
        default:      rdata_d               = '0;  // unmapped reads zero
      endcase
    end
    // mode follows a control write; a reserved code leaves it alone
    if (ctrl_wr) begin
      awake_d = 1'b0;
      unique case (hwdata[CTRL_MODE_LSB +: 2])
        MODE_STANDBY: mode_d = AMSC_STANDBY;
        MODE_WAKEUP:  mode_d = AMSC_WAKEUP;
        MODE_MEASURE: mode_d = AMSC_MEASURE;
        default: begin
          mode_d = mode_q;
          ctrl_d[CTRL_MODE_LSB +: 2] = ctrl_q[CTRL_MODE_LSB +: 2];
        end
      endcase
    end
    // events set flags after the clear so a same cycle set wins
    if (sample_now) begin
      istat_d[IRQ_DATA] = 1'b1;
    end
    if (motion) begin
      istat_d[IRQ_MOTION] = 1'b1;
      awake_d             = 1'b1;
      if (mode_q == AMSC_WAKEUP && ctrl_q[CTRL_AUTO_MEAS] && !ctrl_wr) begin
        mode_d                     = AMSC_MEASURE;
        ctrl_d[CTRL_MODE_LSB +: 2] = MODE_MEASURE;
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q     <= CTRL_RESET;
      mode_q     <= AMSC_STANDBY;
      thresh_q   <= THRESH_RESET;
      act_time_q <= ACT_RESET;
      act_cnt_q  <= '0;
      data_x_q   <= '0;
      data_y_q   <= '0;
      data_z_q   <= '0;
      valid_q    <= 1'b0;
      awake_q    <= 1'b0;
      istat_q    <= '0;
      imask_q    <= '0;
      oct_q      <= '0;
      conv_q     <= 1'b0;
      push_q     <= 1'b0;
      fdata_q    <= '0;
      pend_q     <= 1'b0;
      pwr_q      <= 1'b0;
      paddr_q    <= '0;
      rdata_q    <= '0;
    end else begin
      ctrl_q     <= ctrl_d;
      mode_q     <= mode_d;
      thresh_q   <= thresh_d;
      act_time_q <= act_time_d;
      act_cnt_q  <= act_cnt_d;
      data_x_q   <= data_x_d;
      data_y_q   <= data_y_d;
      data_z_q   <= data_z_d;
      valid_q    <= valid_d;
      awake_q    <= awake_d;
      istat_q    <= istat_d;
      imask_q    <= imask_d;
      oct_q      <= oct_d;
      conv_q     <= conv_d;
      push_q     <= push_d;
      fdata_q    <= fdata_d;
      pend_q     <= pend_d;
      pwr_q      <= pwr_d;
      paddr_q    <= paddr_d;
      rdata_q    <= rdata_d;
    end
  end

  // ==========================================================================
  // outputs
  assign hrdata                  = rdata_q;
  assign hreadyout               = !pend_q;
  assign hresp                   = 1'b0;
  assign sense_enable            = (mode_q != AMSC_STANDBY);
  assign convert_strobe          = conv_q;
  assign filter_bandwidth_select = ctrl_q[CTRL_FILTER_BANDWIDTH_SELECT];
  assign range_select            = ctrl_q[CTRL_RANGE_LSB +: 2];
  assign fifo_push               = push_q;
  assign fifo_data               = fdata_q;
  assign irq                     = |(istat_q & imask_q);
  // pins drive only when not claimed as inputs
  assign first_interrupt_pin_drive  = irq;
  assign first_interrupt_pin_oe     = !ext_clk_en;
  assign second_interrupt_pin_drive = awake_q & ctrl_q[CTRL_WAKE_OUT];
  assign second_interrupt_pin_oe    = !ext_trig_en;

endmodule

/* File: bench/amsc_top_asserts.sv */
/*
  checker for amsc_top: bus wait state, sample pulses, mode and filter changes.
  assumes it is bound to amsc_top and that hready is tied to hreadyout.
*/
`timescale 1ns/1ns
module amsc_top_asserts (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       sense_enable,
  input wire logic       convert_strobe,
  input wire logic       filter_bandwidth_select,
  input wire logic       fifo_push,
  input wire logic       irq,
  input wire logic       first_interrupt_pin_drive
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ======================================
  // bus: an accepted request gets exactly one wait cycle
  sequence s_taken;
    hsel && htrans[1] && hready && hreadyout;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_one_wait: assert property (s_taken |=> s_one_wait)
    else $error("data phase wait count wrong");
  a_resp_okay: assert property (!hresp)
    else $error("response not okay");
  // ======================================
  // modes: only register writes turn sensing on or off, so change follows the wait cycle
  a_reset_quiet: assert property ($rose(hresetn) |-> !sense_enable && !filter_bandwidth_select)
    else $error("reset state not standby quarter");
  a_mode_write: assert property ($changed(sense_enable) |-> !$past(hreadyout))
    else $error("sensing changed without a write");
  a_bw_write: assert property ($changed(filter_bandwidth_select) |-> !$past(hreadyout))
    else $error("filter corner changed without a write");
  // settled standby: a strobe from the last sample event may still land once
  a_standby_quiet: assert property (!sense_enable && !$past(sense_enable) |-> !convert_strobe && !fifo_push)
    else $error("sampling while in standby");
  a_strobe_gap: assert property (convert_strobe |=> !convert_strobe [*8])
    else $error("samples too close");
  a_push_strobe: assert property (fifo_push |-> convert_strobe)
    else $error("push without sample");
  a_irq_source: assert property ($rose(first_interrupt_pin_drive) |-> convert_strobe || !$past(hreadyout))
    else $error("interrupt rose without a sample or a write");
endmodule
bind amsc_top amsc_top_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .sense_enable(sense_enable), .convert_strobe(convert_strobe),
  .filter_bandwidth_select(filter_bandwidth_select), .fifo_push(fifo_push), .irq(irq),
  .first_interrupt_pin_drive(first_interrupt_pin_drive));

/* File: bench/amsc_front_model.sv */
/*
  front model: converter readings and the far side of both dual use pins.
  assumes the bench asks for motion and triggers; pin wires are resolved here.
*/
`timescale 1ns/1ns
module amsc_front_model (
  input  wire logic   motion,
  input  wire logic   trig,
  input  wire logic   pin1_drive,
  input  wire logic   pin1_oe,
  input  wire logic   pin2_drive,
  input  wire logic   pin2_oe,
  output logic [11:0] ax,
  output logic [11:0] ay,
  output logic [11:0] az,
  output logic        pin1,
  output logic        pin2
);
  logic ext_clk;  // sample clock, runs free, phase unrelated to hclk
  initial begin
    ext_clk = 1'b0;
    #37;
    forever #400 ext_clk = ~ext_clk;
  end
  // small steady readings, or a large x swing when motion is asked
  assign ax = motion ? 12'h400 : 12'h010;
  assign ay = 12'hFF0;
  assign az = 12'h005;
  // whoever holds the enable drives the pin
  assign pin1 = pin1_oe ? pin1_drive : ext_clk;
  assign pin2 = pin2_oe ? pin2_drive : trig;
endmodule

/* File: bench/amsc_top_tb.sv */
/*
  testbench for amsc_top: rate table, standby, reset, motion irq, pin inputs.
  assumes amsc_front_model and the bound checker; base period shortened to 20.
*/
`timescale 1ns/1ns
module amsc_top_tb
  import amsc_pkg::*;
;
  typedef struct {logic [31:0] ctrl; int per;} amsc_row_s;
  logic        hclk;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = '0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = '0;
  logic        motion  = 1'b0;
  logic        trig    = 1'b0;
  logic [31:0] hrdata, rd;
  logic [35:0] fifo_data;
  logic [11:0] ax, ay, az;
  logic [1:0]  range_select;
  logic        hreadyout, hresp, sense_enable, convert_strobe, bw, fifo_push, irq;
  logic        p1, p1_drive, p1_oe, p2, p2_drive, p2_oe;
  int          failures = 0, num_checks = 0, n;
  // control word beside the strobe spacing it gives (base period 20)
  amsc_row_s rows [8] = '{'{32'h0000_007E, 20}, '{32'h0000_0012, 40}, '{32'h0000_000E, 80},
    '{32'h0000_000A, 160}, '{32'h0000_0006, 320}, '{32'h0000_0082, 640},
    '{32'h0000_1015, 1280}, '{32'h0000_000C, 0}};
  amsc_top #(.FAST_RATE_DIV(20), .EXT_DIV(4)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .accel_x(ax), .accel_y(ay), .accel_z(az), .sense_enable(sense_enable),
    .convert_strobe(convert_strobe), .filter_bandwidth_select(bw),
    .range_select(range_select), .fifo_push(fifo_push), .fifo_data(fifo_data), .irq(irq),
    .first_interrupt_pin_level(p1), .first_interrupt_pin_drive(p1_drive),
    .first_interrupt_pin_oe(p1_oe), .second_interrupt_pin_level(p2),
    .second_interrupt_pin_drive(p2_drive), .second_interrupt_pin_oe(p2_oe));
  amsc_front_model u_front (.motion(motion), .trig(trig), .pin1_drive(p1_drive),
    .pin1_oe(p1_oe), .pin2_drive(p2_drive), .pin2_oe(p2_oe), .ax(ax), .ay(ay), .az(az),
    .pin1(p1), .pin2(p2));
  // ======================================
  // tasks
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one single ahb transfer; the wait is cut only by the watchdog
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_strobe(input int lim);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (convert_strobe !== 1'b1 && n < lim);
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // run is about 12000 cycles; five times that means a hang
  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    finish_test();
  end
  // ======================================
  // main sequence
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_CTRL, rows[i].ctrl);
      chk("sense", 36'(rows[i].ctrl[1:0] != 2'h0), 36'(sense_enable));
      chk("bandwidth", 36'(rows[i].ctrl[5]), 36'(bw));
      chk("range", 36'(rows[i].ctrl[7:6]), 36'(range_select));
      wait_strobe(3000);
      if (rows[i].per == 0) chk("idle", 36'(3000), 36'(n));
      else begin
        chk("first", 36'(1), 36'(n <= 4 * rows[i].per));
        repeat (2) wait_strobe(3000);
        chk("spacing", 36'(rows[i].per), 36'(n));
        chk("push", 36'(rows[i].ctrl[12]), 36'(fifo_push));
        if (rows[i].ctrl[12]) chk("fifo", 36'h0_05FF_0010, fifo_data);
      end
    end
    bus(1'b0, OFS_DATA_X, '0);
    chk("kept data", 36'h0_0000_0010, 36'(rd));
    do_reset();
    bus(1'b0, OFS_CTRL, '0);
    chk("ctrl reset", 36'h0_0000_000C, 36'(rd));
    // timer of 8 would need 8 slow samples; wake-up must act on the first
    bus(1'b1, OFS_ACT_TIME, 32'h0000_0008);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
    motion <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0000_0C15);
    for (n = 0; n < 1400 && irq !== 1'b1; n++) @(posedge hclk);
    chk("motion irq", 36'(1), 36'(irq));
    chk("wake out", 36'(1), 36'(p2_drive));
    bus(1'b0, OFS_CTRL, '0);
    chk("auto measure", 36'h0_0000_0C16, 36'(rd));
    motion <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_000C);
    chk("kept flag", 36'(1), 36'(irq));
    bus(1'b1, OFS_IRQ_MASK, '0);
    chk("masked", 36'(0), 36'(irq));
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
    chk("unmasked", 36'(1), 36'(irq));
    bus(1'b1, OFS_IRQ_STAT, 32'h0000_0002);
    chk("cleared", 36'(0), 36'(irq));
    // external clock: 4 edges of 8 cycles each per base period
    bus(1'b1, OFS_CTRL, 32'h0000_0116);
    chk("pin1 dir", 36'(0), 36'(p1_oe));
    repeat (3) wait_strobe(3000);
    chk("ext spacing", 36'(32), 36'(n));
    bus(1'b1, OFS_CTRL, 32'h0000_0203);
    chk("pin2 dir", 36'(0), 36'(p2_oe));
    wait_strobe(3000);
    chk("no trigger", 36'(3000), 36'(n));
    repeat (10) @(posedge hclk);
    trig <= 1'b1;
    repeat (2) @(posedge hclk);
    trig <= 1'b0;
    wait_strobe(20);
    chk("trigger", 36'(1), 36'(n <= 6));
    bus(1'b0, OFS_CTRL, '0);
    chk("reserved mode", 36'h0_0000_0202, 36'(rd));
    bus(1'b0, 8'h3C, '0);
    chk("unmapped", 36'(0), 36'(rd));
    finish_test();
  end
endmodule
